/* verilog/clk_synth_params.svh */
// Purpose: shared constants for the clock synthesizer control block
// Assumes: 8-bit address bytes, link clock period as given below
// Notes: times are kept in their own unit, cycle counts derive from them
`ifndef CLK_SYNTH_PARAMS_SVH
`define CLK_SYNTH_PARAMS_SVH

`define WR_ADDR 8'hd2
`define RD_ADDR 8'hd3
`define CMD_DUMMY 8'h00
`define BYTE_COUNT 8'h06
`define CFG_BYTES 6
`define CFG_RESET 8'h00
`define STRAP_BITS 5
`define STRAP_RESET 5'h00

`define REF_CLK_NS 40
`define LINK_CLK_NS 125
`define I2C_MIN_PERIOD_NS 10000
`define SCL_QTR_CYC ((`I2C_MIN_PERIOD_NS + 4 * `REF_CLK_NS - 1) / (4 * `REF_CLK_NS))
`define POR_NS 2000
`define POR_CYC ((`POR_NS + `LINK_CLK_NS - 1) / `LINK_CLK_NS)
`define PWRUP_LAT_US 3000
`define PWRUP_LAT_CYC ((`PWRUP_LAT_US * 1000) / `LINK_CLK_NS)
`define PWRUP_WAIT_CYC (`PWRUP_LAT_CYC / 2)
`define MIN_STOP_HIGH_PERIODS 100

`endif

/* verilog/clk_synth_pkg.sv */
// Purpose: state types for both ends of the configuration link
// Assumes: nothing
// Notes: Gray codes along the usual path
`default_nettype none
package clk_synth_pkg;
   typedef enum logic [2:0] {
      S_IDLE = 3'h0, S_ADDR = 3'h1, S_ACK_ADDR = 3'h3, S_RX = 3'h2,
      S_ACK_RX = 3'h6, S_TX = 3'h7, S_ACK_TX = 3'h5, S_IGNORE = 3'h4
   } slave_state_e;
   typedef enum logic [1:0] {P_ON = 2'h0, P_STOP = 2'h1, P_OFF = 2'h3, P_WAKE = 2'h2} pwr_state_e;
   typedef enum logic [1:0] {H_IDLE = 2'h0, H_START = 2'h1, H_SLOT = 2'h3, H_STOP = 2'h2} host_state_e;
endpackage
`default_nettype wire

/* verilog/i2c_link_if.sv */
// Purpose: two-wire configuration link between host and device
// Assumes: pull-ups on both lines, host alone drives the clock line
// Notes: line levels resolved here from the enables
`default_nettype none
interface i2c_link_if;
   logic scl_host_out;
   logic scl_host_oe;
   logic sda_host_out;
   logic sda_host_oe;
   logic sda_dev_out;
   logic sda_dev_oe;
   logic scl;
   logic sda;
   // Wired-and with pull-up
   assign scl = !(scl_host_oe && !scl_host_out);
   assign sda = !((sda_host_oe && !sda_host_out) || (sda_dev_oe && !sda_dev_out));
   modport host (output scl_host_out, scl_host_oe, sda_host_out, sda_host_oe, input scl, sda);
   modport device (output sda_dev_out, sda_dev_oe, input scl, sda);
endinterface
`default_nettype wire

/* verilog/sync2.sv */
// Purpose: two-stage synchroniser for asynchronous levels
// Assumes: inputs are levels held well beyond two clock periods
// Notes: first stage feeds only the second stage
`default_nettype none
module sync2 #(
   parameter int W = 1,
   parameter logic [W-1:0] INIT = '0
) (
   // Clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // Data
   input wire logic [W-1:0] d_in,
   output logic [W-1:0] q_out
);
   logic [W-1:0] meta;

   // Two flops, nothing taps the first
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         meta <= INIT;
         q_out <= INIT;
      end else begin
         meta <= d_in;
         q_out <= meta;
      end
   end
endmodule
`default_nettype wire

/* verilog/clk_synth_device.sv */
// Purpose: device end: link slave, strap latch, clock stop and power-down
// Assumes: link clock is the internal processor clock domain
// Notes: clock outputs modelled as divided toggles of the link clock
`include "clk_synth_params.svh"
`default_nettype none
module clk_synth_device #(
   parameter int PWRUP_WAIT = `PWRUP_WAIT_CYC,
   parameter int STRAPS = `STRAP_BITS
) (
   // Link clock and reset
   input wire logic internal_processor_clock_in,
   input wire logic rst_n_in,
   // Configuration link
   i2c_link_if.device link,
   // Asynchronous control pins
   input wire logic cpu_stop_n_in,
   input wire logic pci_stop_n_in,
   input wire logic power_down_n_in,
   // Dual function pins
   input wire logic [STRAPS-1:0] dual_pin_in,
   output logic [STRAPS-1:0] dual_pin_out,
   output logic [STRAPS-1:0] dual_pin_oe_out,
   // Clock outputs and status
   output logic cpu_clk_out,
   output logic pci_clk_out,
   output logic ref_clk_out,
   output logic fixed48_clk_out,
   output logic osc_enable_out,
   output logic [STRAPS-1:0] strap_latch_out,
   output logic [8*`CFG_BYTES-1:0] config_out
);
   localparam int WW = $clog2(PWRUP_WAIT + 1);
   localparam int PW = $clog2(`POR_CYC + 1);

   localparam logic [7:0] COUNT_BYTE = `BYTE_COUNT;
   clk_synth_pkg::slave_state_e st;
   clk_synth_pkg::pwr_state_e pwr;
   logic scl, sda, cpu_stop_n, pci_stop_n, pd_n;
   logic [STRAPS-1:0] strap_syn;
   logic scl_q, sda_q, sda_oe, rd, acked;
   logic [7:0] sh;
   logic [3:0] bitcnt, bcnt;
   logic [7:0] next_byte;
   logic [2:0] div, next_div;
   logic [PW-1:0] por_cnt;
   logic por_done;
   logic [WW-1:0] wake_cnt;
   logic run_all, run_cpu, run_pci;

   // Gate a clock so it stops low and restarts only on a fresh rising edge
   function automatic logic gate(input logic run, input logic cur, input logic nat, input logic nat_prev);
      gate = cur ? nat : (run && nat && !nat_prev);
   endfunction

   // Line, control and strap synchronisers; lines and controls idle high, straps low
   sync2 #(.W(5 + STRAPS), .INIT({5'h1f, {STRAPS{1'b0}}})) u_sync_ctl (
      .clk_in(internal_processor_clock_in),
      .rst_n_in(rst_n_in),
      .d_in({link.scl, link.sda, cpu_stop_n_in, pci_stop_n_in, power_down_n_in, dual_pin_in}),
      .q_out({scl, sda, cpu_stop_n, pci_stop_n, pd_n, strap_syn})
   );
   wire scl_rise = scl && !scl_q;
   wire scl_fall = !scl && scl_q;
   wire start_det = scl && scl_q && sda_q && !sda;
   wire stop_det = scl && scl_q && !sda_q && sda;

   // Open-drain data line, value always low
   assign link.sda_dev_out = 1'b0;
   assign link.sda_dev_oe = sda_oe;
   // Read-back byte after the count; for ten bytes past the last the line stays released, then bcnt wraps back to byte 0
   assign next_byte = (bcnt < 4'(`CFG_BYTES)) ? config_out[8*bcnt +: 8] : 8'hff;

   // Previous line levels for edge and condition detection
   always_ff @(posedge internal_processor_clock_in) begin
      if (!rst_n_in) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_q <= scl;
         sda_q <= sda;
      end
   end

   // Link slave; start and stop win over any bit in progress
   always_ff @(posedge internal_processor_clock_in) begin
      if (!rst_n_in) begin
         st <= clk_synth_pkg::S_IDLE;
         sh <= 8'h00;
         bitcnt <= 4'h0;
         bcnt <= 4'h0;
         rd <= 1'b0;
         acked <= 1'b0;
         sda_oe <= 1'b0;
         config_out <= {`CFG_BYTES{`CFG_RESET}};
      end else if (start_det) begin
         st <= clk_synth_pkg::S_ADDR;
         bitcnt <= 4'h0;
         sda_oe <= 1'b0;
      end else if (stop_det) begin
         st <= clk_synth_pkg::S_IDLE;
         sda_oe <= 1'b0;
      end else begin
         case (st)
            clk_synth_pkg::S_ADDR: begin
               if (scl_rise) begin
                  sh <= {sh[6:0], sda};
                  bitcnt <= bitcnt + 4'h1;
               end else if (scl_fall && bitcnt == 4'h8) begin
                  if (sh == `WR_ADDR || sh == `RD_ADDR) begin
                     sda_oe <= 1'b1;
                     rd <= sh[0];
                     st <= clk_synth_pkg::S_ACK_ADDR;
                  end else begin
                     st <= clk_synth_pkg::S_IGNORE;
                  end
               end
            end
            clk_synth_pkg::S_ACK_ADDR: begin
               if (scl_fall) begin
                  bitcnt <= 4'h0;
                  bcnt <= 4'h0;
                  if (rd) begin
                     sh <= `BYTE_COUNT;
                     sda_oe <= !COUNT_BYTE[7];
                     st <= clk_synth_pkg::S_TX;
                  end else begin
                     sda_oe <= 1'b0;
                     st <= clk_synth_pkg::S_RX;
                  end
               end
            end
            clk_synth_pkg::S_RX: begin
               if (scl_rise) begin
                  sh <= {sh[6:0], sda};
                  bitcnt <= bitcnt + 4'h1;
               end else if (scl_fall && bitcnt == 4'h8) begin
                  // First two bytes are command and count, dropped
                  if (bcnt >= 4'h2 && bcnt < 4'(`CFG_BYTES + 2)) begin
                     config_out[8*(bcnt - 4'h2) +: 8] <= sh;
                  end
                  if (bcnt != 4'hf) begin
                     bcnt <= bcnt + 4'h1;
                  end
                  sda_oe <= 1'b1;
                  st <= clk_synth_pkg::S_ACK_RX;
               end
            end
            clk_synth_pkg::S_ACK_RX: begin
               if (scl_fall) begin
                  sda_oe <= 1'b0;
                  bitcnt <= 4'h0;
                  st <= clk_synth_pkg::S_RX;
               end
            end
            clk_synth_pkg::S_TX: begin
               if (scl_rise) begin
                  bitcnt <= bitcnt + 4'h1;
               end else if (scl_fall) begin
                  if (bitcnt == 4'h8) begin
                     sda_oe <= 1'b0;
                     st <= clk_synth_pkg::S_ACK_TX;
                  end else begin
                     sh <= {sh[6:0], 1'b0};
                     sda_oe <= !sh[6];
                  end
               end
            end
            clk_synth_pkg::S_ACK_TX: begin
               if (scl_rise) begin
                  acked <= !sda;
               end else if (scl_fall) begin
                  if (acked) begin
                     sh <= next_byte;
                     sda_oe <= !next_byte[7];
                     bcnt <= bcnt + 4'h1;
                     bitcnt <= 4'h0;
                     st <= clk_synth_pkg::S_TX;
                  end else begin
                     st <= clk_synth_pkg::S_IGNORE;
                  end
               end
            end
            default: begin // Idle and ignored transfers keep the line released
               sda_oe <= 1'b0;
            end
         endcase
      end
   end

   // Power-up wait, then strap capture and pin turnaround
   always_ff @(posedge internal_processor_clock_in) begin
      if (!rst_n_in) begin
         por_cnt <= '0;
         por_done <= 1'b0;
         strap_latch_out <= `STRAP_RESET;
         dual_pin_oe_out <= '0;
      end else if (!por_done) begin
         if (por_cnt == PW'(`POR_CYC - 1)) begin
            por_done <= 1'b1;
            strap_latch_out <= strap_syn;
            dual_pin_oe_out <= '1;
         end else begin
            por_cnt <= por_cnt + PW'(1);
         end
      end
   end

   // Power-down sequencer; oscillators go off only once every output is low
   always_ff @(posedge internal_processor_clock_in) begin
      if (!rst_n_in) begin
         pwr <= clk_synth_pkg::P_ON;
         osc_enable_out <= 1'b1;
         wake_cnt <= '0;
      end else begin
         case (pwr)
            clk_synth_pkg::P_ON: begin
               if (!pd_n) begin
                  pwr <= clk_synth_pkg::P_STOP;
               end
            end
            clk_synth_pkg::P_STOP: begin
               if (!cpu_clk_out && !pci_clk_out && !ref_clk_out && !fixed48_clk_out && dual_pin_out == '0) begin
                  osc_enable_out <= 1'b0;
                  pwr <= clk_synth_pkg::P_OFF;
               end
            end
            clk_synth_pkg::P_OFF: begin
               if (pd_n) begin
                  osc_enable_out <= 1'b1;
                  wake_cnt <= '0;
                  pwr <= clk_synth_pkg::P_WAKE;
               end
            end
            clk_synth_pkg::P_WAKE: begin
               if (!pd_n) begin
                  pwr <= clk_synth_pkg::P_STOP;
               end else if (wake_cnt == WW'(PWRUP_WAIT - 1)) begin
                  pwr <= clk_synth_pkg::P_ON;
               end else begin
                  wake_cnt <= wake_cnt + WW'(1);
               end
            end
            default: begin
               pwr <= clk_synth_pkg::P_ON;
            end
         endcase
      end
   end

   // Stop inputs only matter while fully powered
   assign run_all = por_done && pwr == clk_synth_pkg::P_ON;
   assign run_cpu = run_all && cpu_stop_n;
   assign run_pci = run_all && pci_stop_n;
   assign next_div = div + 3'h1;

   // Gated clock outputs; a high phase in flight always completes,
   // and the divider never stops so restarts stay phase aligned
   always_ff @(posedge internal_processor_clock_in) begin
      if (!rst_n_in) begin
         div <= 3'h0;
         cpu_clk_out <= 1'b0;
         pci_clk_out <= 1'b0;
         ref_clk_out <= 1'b0;
         fixed48_clk_out <= 1'b0;
         dual_pin_out <= '0;
      end else begin
         div <= next_div;
         cpu_clk_out <= gate(run_cpu, cpu_clk_out, next_div[0], div[0]);
         pci_clk_out <= gate(run_pci, pci_clk_out, next_div[1], div[1]);
         fixed48_clk_out <= gate(run_all, fixed48_clk_out, next_div[0], div[0]);
         ref_clk_out <= gate(run_all, ref_clk_out, next_div[2], div[2]);
         for (int i = 0; i < STRAPS; i++) begin
            dual_pin_out[i] <= gate(run_all && por_done, dual_pin_out[i], next_div[1], div[1]);
         end
      end
   end
endmodule
`default_nettype wire

/* verilog/clk_synth_host.sv */
// Purpose: host end: block write and block read master of the link
// Assumes: no clock stretching by the slave
// Notes: clock line derived from ref clock by a quarter-bit divider
`include "clk_synth_params.svh"
`default_nettype none
module clk_synth_host (
   // Clock and reset
   input wire logic ref_clk_in,
   input wire logic rst_n_in,
   // Configuration link
   i2c_link_if.host link,
   // Command port
   input wire logic wr_req_in,
   input wire logic rd_req_in,
   input wire logic [8*`CFG_BYTES-1:0] wr_data_in,
   output logic busy_out,
   output logic done_out,
   output logic nack_out,
   output logic [8*`CFG_BYTES-1:0] rd_data_out
);
   clk_synth_pkg::host_state_e st;
   logic [6:0] qcnt;
   logic [1:0] ph;
   logic [3:0] slot, idx;
   logic rd, scl_oe, sda_oe, sda_s;
   logic [7:0] tx_sh, rx_sh;
   logic [8*`CFG_BYTES-1:0] wdata;

   // Byte sent at position n of a transfer
   function automatic logic [7:0] host_byte(input logic [3:0] n, input logic r, input logic [8*`CFG_BYTES-1:0] d);
      if (n == 4'h0) begin
         host_byte = r ? `RD_ADDR : `WR_ADDR;
      end else if (n == 4'h1) begin
         host_byte = `CMD_DUMMY;
      end else if (n == 4'h2) begin
         host_byte = `BYTE_COUNT;
      end else begin
         host_byte = d[8*(n-4'h3) +: 8];
      end
   endfunction

   wire tick = qcnt == 7'(`SCL_QTR_CYC - 1);
   wire txing = !(rd && idx != 4'h0);
   wire last = idx == (rd ? 4'(`CFG_BYTES + 1) : 4'(`CFG_BYTES + 2));

   sync2 #(.W(1), .INIT(1'b1)) u_sync_sda (
      .clk_in(ref_clk_in),
      .rst_n_in(rst_n_in),
      .d_in(link.sda),
      .q_out(sda_s)
   );

   // Open-drain lines, value always low
   assign link.scl_host_out = 1'b0;
   assign link.sda_host_out = 1'b0;
   assign link.scl_host_oe = scl_oe;
   assign link.sda_host_oe = sda_oe;

   // Quarter-bit timer, idle when no transfer
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in || st == clk_synth_pkg::H_IDLE || tick) begin
         qcnt <= 7'h00;
      end else begin
         qcnt <= qcnt + 7'h01;
      end
   end

   // Transfer sequencer: each bit is four quarters
   always_ff @(posedge ref_clk_in) begin
      if (!rst_n_in) begin
         st <= clk_synth_pkg::H_IDLE;
         ph <= 2'h0;
         slot <= 4'h0;
         idx <= 4'h0;
         rd <= 1'b0;
         scl_oe <= 1'b0;
         sda_oe <= 1'b0;
         tx_sh <= 8'h00;
         rx_sh <= 8'h00;
         wdata <= '0;
         busy_out <= 1'b0;
         done_out <= 1'b0;
         nack_out <= 1'b0;
         rd_data_out <= '0;
      end else begin
         done_out <= 1'b0;
         case (st)
            clk_synth_pkg::H_IDLE: begin
               if (wr_req_in || rd_req_in) begin
                  rd <= rd_req_in && !wr_req_in;
                  wdata <= wr_data_in;
                  busy_out <= 1'b1;
                  nack_out <= 1'b0;
                  ph <= 2'h0;
                  st <= clk_synth_pkg::H_START;
               end
            end
            clk_synth_pkg::H_START: begin
               if (tick) begin
                  ph <= ph + 2'h1;
                  if (ph == 2'h0) begin
                     sda_oe <= 1'b1;
                  end else if (ph == 2'h1) begin
                     scl_oe <= 1'b1;
                     idx <= 4'h0;
                     slot <= 4'h0;
                     tx_sh <= host_byte(4'h0, rd, wdata);
                     ph <= 2'h0;
                     st <= clk_synth_pkg::H_SLOT;
                  end
               end
            end
            clk_synth_pkg::H_SLOT: begin
               if (tick) begin
                  ph <= ph + 2'h1;
                  case (ph)
                     2'h0: begin
                        if (slot < 4'h8) begin
                           sda_oe <= txing ? !tx_sh[7] : 1'b0;
                        end else begin
                           sda_oe <= !txing;
                        end
                     end
                     2'h1: begin
                        scl_oe <= 1'b0;
                     end
                     2'h2: begin
                        if (slot < 4'h8) begin
                           rx_sh <= {rx_sh[6:0], sda_s};
                           tx_sh <= {tx_sh[6:0], 1'b0};
                        end else if (txing && sda_s) begin
                           nack_out <= 1'b1;
                        end
                     end
                     default: begin
                        scl_oe <= 1'b1;
                        if (slot == 4'h8) begin
                           slot <= 4'h0;
                           if (rd && idx >= 4'h2) begin
                              rd_data_out[8*(idx-4'h2) +: 8] <= rx_sh;
                           end
                           if (last || nack_out) begin
                              st <= clk_synth_pkg::H_STOP;
                           end else begin
                              idx <= idx + 4'h1;
                              tx_sh <= host_byte(idx + 4'h1, rd, wdata);
                           end
                        end else begin
                           slot <= slot + 4'h1;
                        end
                     end
                  endcase
               end
            end
            clk_synth_pkg::H_STOP: begin
               if (tick) begin
                  ph <= ph + 2'h1;
                  case (ph)
                     2'h0: sda_oe <= 1'b1;
                     2'h1: scl_oe <= 1'b0;
                     2'h2: sda_oe <= 1'b0;
                     default: begin
                        busy_out <= 1'b0;
                        done_out <= 1'b1;
                        st <= clk_synth_pkg::H_IDLE;
                     end
                  endcase
               end
            end
            default: begin
               st <= clk_synth_pkg::H_IDLE;
            end
         endcase
      end
   end
endmodule
`default_nettype wire

/* tb/clk_synth_link_props.sv */
// Purpose: link and clock-stop checks beside the link
// Assumes: outputs are divided toggles of the link clock
// Notes: one domain only, the link clock
`default_nettype none
module clk_synth_link_props (
   // Clock and reset
   input wire logic internal_processor_clock_in,
   input wire logic rst_n_in,
   // Link lines
   input wire logic scl,
   input wire logic sda_dev_oe,
   input wire logic sda_dev_out,
   // Control pins
   input wire logic cpu_stop_n_in,
   input wire logic pci_stop_n_in,
   input wire logic power_down_n_in,
   input wire logic [4:0] dual_pin_in,
   // Device outputs
   input wire logic [4:0] dual_pin_out,
   input wire logic [4:0] dual_pin_oe_out,
   input wire logic [4:0] strap_latch_out,
   input wire logic cpu_clk_out,
   input wire logic pci_clk_out,
   input wire logic ref_clk_out,
   input wire logic fixed48_clk_out,
   input wire logic osc_enable_out
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge internal_processor_clock_in); endclocking
   default disable iff (!rst_n_in);
   // Clocks only count once started and powered
   wire run = dual_pin_oe_out[0] && osc_enable_out;
   property p_pull_low; sda_dev_oe |-> !sda_dev_out; endproperty
   a_pull_low: assert property (p_pull_low) else $error("device drove data high");
   property p_data_moves; $changed(sda_dev_oe) |-> !scl; endproperty
   a_data_moves: assert property (p_data_moves) else $error("data moved with clock high");
   property p_strap; $rose(dual_pin_oe_out[0]) |-> strap_latch_out == dual_pin_in; endproperty
   a_strap: assert property (p_strap) else $error("strap latch wrong");
   property p_halt; (!cpu_stop_n_in)[*6] |-> !cpu_clk_out; endproperty
   a_halt: assert property (p_halt) else $error("processor clock not halted low");
   property p_restart; $rose(cpu_stop_n_in) && run && power_down_n_in |-> ##[1:10] cpu_clk_out; endproperty
   a_restart: assert property (p_restart) else $error("processor clock slow to restart");
   property p_others; (!cpu_stop_n_in && pci_stop_n_in && power_down_n_in && run)[*4] |-> $changed(fixed48_clk_out);
   endproperty
   a_others: assert property (p_others) else $error("fixed clock stalled");
   property p_pd_low; (!power_down_n_in)[*8] |-> ##2 !(cpu_clk_out | pci_clk_out | ref_clk_out | fixed48_clk_out)
      && dual_pin_out == 5'h00; endproperty
   a_pd_low: assert property (p_pd_low) else $error("clock high in power-down");
   property p_osc_off; $fell(osc_enable_out) |-> !(cpu_clk_out | pci_clk_out | ref_clk_out | fixed48_clk_out);
   endproperty
   a_osc_off: assert property (p_osc_off) else $error("oscillator off before clocks low");
   property p_wake; $rose(power_down_n_in) |-> ##[1:60] cpu_clk_out; endproperty
   a_wake: assert property (p_wake) else $error("clocks slow to return");
endmodule
`default_nettype wire

/* tb/clock_synth_config_and_stop_control_tb.sv */
// Purpose: bench joining host and device ends over the link
// Assumes: short power-up wait keeps the run brief
// Notes: each end runs on its own clock
`default_nettype none
module clock_synth_config_and_stop_control_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [4:0] STRAP = 5'h15;
   localparam logic [47:0] PAT = 48'ha5c3_1e69_f00f;
   logic ref_clk_in, lclk, rst_n_in, lrst_n, wr_req, rd_req, cpu_stop_n, pci_stop_n, pd_n;
   logic busy, done, nack, cpu_clk, pci_clk, ref_out, f48, osc;
   logic [4:0] dpin_out, dpin_oe, strap;
   logic [47:0] cfg, rd_data;
   int fail_count = 0;
   int cmp_count = 0;
   int nc, np;
   i2c_link_if link ();
   clk_synth_host clk_synth_host_i (.ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .link(link.host),
      .wr_req_in(wr_req), .rd_req_in(rd_req), .wr_data_in(PAT), .busy_out(busy), .done_out(done),
      .nack_out(nack), .rd_data_out(rd_data));
   clk_synth_device #(.PWRUP_WAIT(20)) clk_synth_device_i (.internal_processor_clock_in(lclk),
      .rst_n_in(lrst_n), .link(link.device), .cpu_stop_n_in(cpu_stop_n), .pci_stop_n_in(pci_stop_n),
      .power_down_n_in(pd_n), .dual_pin_in(STRAP), .dual_pin_out(dpin_out), .dual_pin_oe_out(dpin_oe),
      .cpu_clk_out(cpu_clk), .pci_clk_out(pci_clk), .ref_clk_out(ref_out), .fixed48_clk_out(f48),
      .osc_enable_out(osc), .strap_latch_out(strap), .config_out(cfg));
   clk_synth_link_props clk_synth_link_props_i (.internal_processor_clock_in(lclk), .rst_n_in(lrst_n),
      .scl(link.scl), .sda_dev_oe(link.sda_dev_oe), .sda_dev_out(link.sda_dev_out), .cpu_stop_n_in(cpu_stop_n),
      .pci_stop_n_in(pci_stop_n), .power_down_n_in(pd_n), .dual_pin_in(STRAP), .dual_pin_out(dpin_out),
      .dual_pin_oe_out(dpin_oe), .strap_latch_out(strap), .cpu_clk_out(cpu_clk), .pci_clk_out(pci_clk),
      .ref_clk_out(ref_out), .fixed48_clk_out(f48), .osc_enable_out(osc));
   // Two clocks, phases unrelated
   initial begin
      ref_clk_in = 0;
      forever #20 ref_clk_in = ~ref_clk_in;
   end
   initial begin
      lclk = 0;
      #7;
      forever #62.5 lclk = ~lclk;
   end
   // Device reset counted on its own clock, too few host edges otherwise
   initial begin
      lrst_n = 0;
      repeat (6) @(posedge lclk);
      lrst_n <= 1;
   end
   task automatic chk(input logic [47:0] got, exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One host transfer, bounded wait on the done pulse
   task automatic xfer(input logic wr);
      int n;
      @(posedge ref_clk_in);
      wr_req <= wr;
      rd_req <= !wr;
      @(posedge ref_clk_in);
      wr_req <= 0;
      rd_req <= 0;
      @(negedge ref_clk_in);
      chk(48'(busy), 48'h1);
      for (n = 0; n < 40000 && done !== 1'b1; n++) @(negedge ref_clk_in);
      chk(48'(n < 40000), 48'h1);
      chk(48'(busy), 48'h0);
   endtask
   // Counts processor and bus clock edges over a span
   task automatic watch(input int cyc);
      logic pc, pp;
      nc = 0;
      np = 0;
      pc = cpu_clk;
      pp = pci_clk;
      repeat (cyc) begin
         @(negedge lclk);
         nc += int'(cpu_clk !== pc);
         np += int'(pci_clk !== pp);
         pc = cpu_clk;
         pp = pci_clk;
      end
   endtask
   task automatic stop_test;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // Watchdog well past the expected run
   initial begin
      #3000000;
      fail_count++;
      stop_test();
   end
   initial begin
      rst_n_in = 0;
      wr_req = 0;
      rd_req = 0;
      cpu_stop_n = 1;
      pci_stop_n = 1;
      pd_n = 1;
      repeat (6) @(posedge ref_clk_in);
      rst_n_in <= 1;
      repeat (40) @(negedge lclk);
      chk(cfg, 48'h0);
      chk(48'(strap), 48'(STRAP));
      chk(48'(dpin_oe), 48'h1f);
      $display("reset test done");
      xfer(1);
      chk(cfg, PAT);
      chk(48'(nack), 48'h0);
      xfer(0);
      chk(rd_data, PAT);
      $display("link test done");
      @(posedge ref_clk_in);
      cpu_stop_n <= 0;
      watch(6);
      watch(20);
      chk(48'(nc), 48'h0);
      chk(48'(np > 0), 48'h1);
      @(posedge ref_clk_in);
      cpu_stop_n <= 1;
      watch(10);
      chk(48'(nc > 0), 48'h1);
      watch(220);
      $display("processor stop test done");
      @(posedge ref_clk_in);
      pd_n <= 0;
      cpu_stop_n <= 0;
      pci_stop_n <= 0;
      watch(12);
      watch(20);
      chk(48'(nc + np), 48'h0);
      chk(48'({cpu_clk, pci_clk, ref_out, f48, dpin_out}), 48'h0);
      chk(48'(osc), 48'h0);
      @(posedge ref_clk_in);
      pd_n <= 1;
      cpu_stop_n <= 1;
      pci_stop_n <= 1;
      watch(40);
      chk({47'h0, osc}, 48'h1);
      chk(48'(nc > 0), 48'h1);
      $display("power-down test done");
      stop_test();
   end
endmodule
`default_nettype wire
